// ==== hw/nvm_access_map.svh ====
// register indices, field positions, reset values and timing figures
// assumes inclusion by the block and its package users only
`ifndef NVM_ACCESS_MAP_SVH
`define NVM_ACCESS_MAP_SVH
`define NVM_IDX_ADDR_HIGH 2'h0
`define NVM_IDX_ADDR_LOW 2'h1
`define NVM_IDX_DATA 2'h2
`define NVM_IDX_CONTROL 2'h3
`define NVM_BIT_READ 0
`define NVM_BIT_PROG 1
`define NVM_BIT_ARM 2
`define NVM_BIT_RIE 3
`define NVM_BIT_MODE_LO 4
`define NVM_BIT_MODE_HI 5
`define NVM_DATA_RESET 8'h00
`define NVM_MODE_RESET 2'h0
`define NVM_ARM_CYCLES 3'h4
`define NVM_READ_STALL 3'h4
`define NVM_PROG_STALL 3'h2
`define NVM_CLK_KHZ 40000
`define NVM_ATOMIC_TIME_US 3400
`define NVM_SPLIT_TIME_US 1800
`define NVM_ERASED_BYTE 8'hff
`endif

// ==== hw/nvm_access_pkg.sv ====
// types shared by the eeprom access block and its environment
// assumes the constants of nvm_access_map.svh
package nvm_access_pkg;
  // one io register access from the core, at most one per cycle
  typedef struct packed {
    logic       wr;     // write strobe
    logic       rd;     // read strobe
    logic [1:0] index;  // register index
    logic [7:0] wdata;  // write data
  } io_req_s;
  // programming action chosen by the mode field
  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'h0,
    MODE_ERASE  = 2'h1,
    MODE_WRITE  = 2'h2,
    MODE_RSVD   = 2'h3
  } prog_mode_e;
  // controller state
  typedef enum logic {ST_IDLE, ST_PROG} prog_state_e;
endpackage : nvm_access_pkg

// ==== hw/byte_eeprom_access_control.sv ====
// byte eeprom access control: address, data and control registers,
// armed program strobe, read strobe, core stall and ready request.
// assumes one core io access per cycle, synchronous to clk_sys.
// Operation
// - mode field picks atomic, erase or write
// - mode writes ignored while programming
// - reset clears mode unless programming
// - ready enable gated by global enable
// - ready request is level while idle
// - armed strobe starts programming unless mode is reserved
// - unarmed strobe does nothing
// - arm bit self clears after four cycles
// - strobe reads one until timer ends
// - accepted strobe stalls core two cycles
// - read strobe loads data register immediately
// - read strobe stalls core four cycles
// - no read, no address write while busy
// - nine bit address, high bits read zero
// - address undefined after reset
// - data register feeds writes, takes reads
// - control bits seven, six read zero
// - reset lets running operation finish
// - no other operation while programming
`timescale 1ns/1ps
`include "nvm_access_map.svh"
module byte_eeprom_access_control #(
  parameter int DEPTH         = 512,
  parameter int ATOMIC_CYCLES = `NVM_ATOMIC_TIME_US * `NVM_CLK_KHZ / 1000,
  parameter int SPLIT_CYCLES  = `NVM_SPLIT_TIME_US * `NVM_CLK_KHZ / 1000
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    porRst,
  input  wire logic                    ce,
  input  wire logic                    gieBit,
  input  wire nvm_access_pkg::io_req_s ioReq,
  output logic [7:0]                   ioRdata,
  output logic                         cpuStall,
  output logic                         readyIrq,
  output logic                         progBusy
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(ATOMIC_CYCLES + 1);

  logic [7:0]    mem [DEPTH];    // the eeprom array itself
  logic [AW-1:0] nvmAddress;     // linear byte address, no reset
  logic [7:0]    nvmData;        // data register
  logic [1:0]    progMode;       // mode field
  logic          readyIrqEnable; // ready request enable
  logic [2:0]    armCnt;         // arm window down counter
  logic [2:0]    stallCnt;       // core halt down counter
  logic [CW-1:0] progCnt;        // programming time down counter
  logic [AW-1:0] progAddr;       // address latched at start
  logic [7:0]    progData;       // data latched at start
  logic [1:0]    opMode;         // mode latched at start
  nvm_access_pkg::prog_state_e state;

  // decode of the core access
  wire ctrlWr  = ioReq.wr && (ioReq.index == `NVM_IDX_CONTROL);
  wire dataWr  = ioReq.wr && (ioReq.index == `NVM_IDX_DATA);
  wire lowWr   = ioReq.wr && (ioReq.index == `NVM_IDX_ADDR_LOW);
  wire highWr  = ioReq.wr && (ioReq.index == `NVM_IDX_ADDR_HIGH);
  wire busy    = (state == nvm_access_pkg::ST_PROG);
  wire armed   = (armCnt != 3'h0);
  wire [1:0] wrMode = ioReq.wdata[`NVM_BIT_MODE_HI:`NVM_BIT_MODE_LO];
  wire wantProg = ctrlWr && ioReq.wdata[`NVM_BIT_PROG];
  wire wantRead = ctrlWr && ioReq.wdata[`NVM_BIT_READ];
  wire wantArm  = ctrlWr && ioReq.wdata[`NVM_BIT_ARM];
  // the mode of this very write is the one used; reserved starts nothing
  wire startGo = wantProg && armed && !busy
                 && (wrMode != nvm_access_pkg::MODE_RSVD);
  wire readGo  = wantRead && !busy;
  wire progDone = busy && (progCnt == '0);

  // load value of the programming timer, one count per cycle
  function automatic logic [CW-1:0] op_cycles(input logic [1:0] m);
    if (m == nvm_access_pkg::MODE_ATOMIC)
      op_cycles = CW'(ATOMIC_CYCLES - 1);
    else
      op_cycles = CW'(SPLIT_CYCLES - 1);
  endfunction : op_cycles

  // byte left in the array when an operation ends
  function automatic logic [7:0] op_result(input logic [1:0] m,
      input logic [7:0] old, input logic [7:0] dat);
    unique case (m)
      nvm_access_pkg::MODE_ATOMIC: op_result = dat;
      nvm_access_pkg::MODE_ERASE:  op_result = `NVM_ERASED_BYTE;
      nvm_access_pkg::MODE_WRITE:  op_result = old & dat;  // only clears bits
      default:                     op_result = old;
    endcase
  endfunction : op_result

  // programming engine; device reset spares it, only power loss stops it
  always_ff @(posedge clk_sys) begin
    if (porRst) begin
      state   <= nvm_access_pkg::ST_IDLE;
      progCnt <= '0;
    end else if (ce) begin
      if (startGo) begin
        state    <= nvm_access_pkg::ST_PROG;
        progCnt  <= op_cycles(wrMode);
        progAddr <= nvmAddress;
        progData <= nvmData;
        opMode   <= wrMode;
      end else if (progDone) begin
        state <= nvm_access_pkg::ST_IDLE;
      end else if (busy) begin
        progCnt <= progCnt - CW'(1);
      end
    end
  end

  // array update at the end of an operation
  always_ff @(posedge clk_sys) begin
    if (ce && !porRst && progDone)
      mem[progAddr] <= op_result(opMode, mem[progAddr], progData);
  end

  // address register: frozen while programming, never reset
  always_ff @(posedge clk_sys) begin
    if (ce && !busy) begin
      if (lowWr)
        nvmAddress[7:0] <= ioReq.wdata;
      if (highWr)
        nvmAddress[AW-1:8] <= ioReq.wdata[AW-9:0];
    end
  end

  // mode field survives a reset taken during programming
  always_ff @(posedge clk_sys) begin
    if (porRst)
      progMode <= `NVM_MODE_RESET;
    else if (rst && !busy)
      progMode <= `NVM_MODE_RESET;
    else if (!rst && ce && ctrlWr && !busy)
      progMode <= wrMode;
  end

  // data register, control flags, arm window and stall counter
  always_ff @(posedge clk_sys) begin
    if (porRst || rst) begin
      nvmData        <= `NVM_DATA_RESET;
      readyIrqEnable <= 1'b0;
      armCnt         <= 3'h0;
      stallCnt       <= 3'h0;
    end else if (ce) begin
      if (readGo)
        nvmData <= mem[nvmAddress];
      else if (dataWr)
        nvmData <= ioReq.wdata;
      if (ctrlWr)
        readyIrqEnable <= ioReq.wdata[`NVM_BIT_RIE];
      // a new arm write restarts the window
      if (wantArm)
        armCnt <= `NVM_ARM_CYCLES;
      else if (armed)
        armCnt <= armCnt - 3'h1;
      if (startGo)
        stallCnt <= `NVM_PROG_STALL;
      else if (readGo)
        stallCnt <= `NVM_READ_STALL;
      else if (stallCnt != 3'h0)
        stallCnt <= stallCnt - 3'h1;
    end
  end

  // read data, registered one cycle after the read strobe of the bus
  wire [7:0] ctrlView = {2'h0, progMode, readyIrqEnable,
                         armed, busy, 1'b0};
  wire [7:0] highView = 8'(nvmAddress[AW-1:8]);
  always_ff @(posedge clk_sys) begin
    if (porRst || rst)
      ioRdata <= 8'h00;
    else if (ce && ioReq.rd) begin
      unique case (ioReq.index)
        `NVM_IDX_ADDR_HIGH: ioRdata <= highView;
        `NVM_IDX_ADDR_LOW:  ioRdata <= nvmAddress[7:0];
        `NVM_IDX_DATA:      ioRdata <= nvmData;
        `NVM_IDX_CONTROL:   ioRdata <= ctrlView;
      endcase
    end
  end

  // halt and ready request; level, not an event
  assign cpuStall = (stallCnt != 3'h0);
  assign readyIrq = readyIrqEnable && gieBit && !busy;
  assign progBusy = busy;

  // checks
  chk_arm_expires: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    wantArm ##1 !wantArm [*4] |=> !armed)
    else $error("arm bit outlived its window");
  // the arm bit must still be visible on the fourth cycle after its write
  chk_arm_window: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    wantArm ##1 !wantArm [*4] |-> armed)
    else $error("arm window closed too early");
  chk_unarmed_idle: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    (wantProg && !armed && !busy) |=> !busy)
    else $error("unarmed strobe started programming");
  chk_armed_start: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    (wantProg && armed && !busy && wrMode != 2'h3) |=> busy && progAddr == $past(nvmAddress))
    else $error("armed strobe did not start");
  chk_rsvd_mode: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    (wantProg && armed && !busy && wrMode == 2'h3) |=> !busy)
    else $error("reserved mode started an operation");
  chk_mode_frozen: assert property (@(posedge clk_sys)
    disable iff (porRst || !ce)
    (busy && ctrlWr) |=> $stable(progMode))
    else $error("mode changed while programming");
  chk_prog_stall: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    startGo |=> cpuStall [*2] ##1 !cpuStall)
    else $error("program stall not two cycles");
  chk_read_stall: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    readGo |=> cpuStall [*4] ##1 !cpuStall)
    else $error("read stall not four cycles");
  chk_read_data: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    readGo |=> nvmData == mem[$past(nvmAddress)])
    else $error("read strobe did not load data");
  chk_addr_frozen: assert property (@(posedge clk_sys)
    disable iff (porRst || !ce)
    (busy && (lowWr || highWr)) |=> $stable(nvmAddress))
    else $error("address changed while programming");
  chk_reset_spares: assert property (@(posedge clk_sys)
    disable iff (porRst || !ce)
    (rst && busy && progCnt != '0) |=> busy && $stable(progMode))
    else $error("reset broke a running operation");
  chk_reset_mode: assert property (@(posedge clk_sys)
    disable iff (porRst)
    (rst && !busy) |=> progMode == 2'h0)
    else $error("reset left mode set");
  chk_ready_level: assert property (@(posedge clk_sys)
    disable iff (porRst || !ce)
    $fell(busy) && readyIrqEnable && gieBit |-> readyIrq)
    else $error("ready request missing at idle");
  chk_busy_quiet: assert property (@(posedge clk_sys)
    busy || !gieBit |-> !readyIrq)
    else $error("ready request while busy or gated");
  chk_timer_end: assert property (@(posedge clk_sys)
    disable iff (porRst || !ce)
    progDone |=> !busy && !progDone)
    else $error("operation did not end on count");
  // an idle mode write lands in the field on the next cycle
  chk_mode_write: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    (ctrlWr && !busy) |=> progMode == $past(wrMode))
    else $error("mode write lost while idle");
  // the enable follows every control write, busy or not
  chk_rie_write: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    ctrlWr |=> readyIrqEnable == $past(ioReq.wdata[`NVM_BIT_RIE]))
    else $error("ready enable not written");
  // a data write always lands, programming latches its own copy
  chk_data_write: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    dataWr |=> nvmData == $past(ioReq.wdata))
    else $error("data register write lost");
  chk_prog_data: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    startGo |=> progData == $past(nvmData))
    else $error("operation took the wrong data");
  // register views seen by the core
  chk_high_zero: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    (ioReq.rd && ioReq.index == `NVM_IDX_ADDR_HIGH) |=> ioRdata[7:1] == 7'h00)
    else $error("unused address bits read as one");
  chk_ctrl_reserved: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    (ioReq.rd && ioReq.index == `NVM_IDX_CONTROL) |=> ioRdata[7:6] == 2'h0)
    else $error("reserved control bits read as one");
  chk_strobe_bit: assert property (@(posedge clk_sys)
    disable iff (porRst || rst || !ce)
    (ioReq.rd && ioReq.index == `NVM_IDX_CONTROL) |=> ioRdata[1] == $past(busy))
    else $error("strobe bit does not track programming");
  // only a supply reset may stop the engine, and it clears the mode too
  chk_porst_idle: assert property (@(posedge clk_sys)
    porRst |=> !busy && progMode == 2'h0)
    else $error("supply reset left engine running");
  // an erase leaves the erased pattern behind
  chk_erase_result: assert property (@(posedge clk_sys)
    disable iff (porRst || !ce)
    (progDone && opMode == 2'h1) |=> mem[$past(progAddr)] == `NVM_ERASED_BYTE)
    else $error("erase left data behind");
  cov_atomic: cover property (@(posedge clk_sys)
    startGo && wrMode == 2'h0);
  cov_read: cover property (@(posedge clk_sys) readGo);
  cov_reset_busy: cover property (@(posedge clk_sys) rst && busy);
  cov_done: cover property (@(posedge clk_sys) progDone);
  // reserved mode strobe, which must stay a no-op
  cov_reserved: cover property (@(posedge clk_sys)
    wantProg && armed && !busy && wrMode == 2'h3);
endmodule : byte_eeprom_access_control

// ==== verification/core_model.sv ====
// core side model: issues one io register access at a time
// assumes a free running clk_sys and honours the block's stall
`timescale 1ns/1ps
module core_model (
  input  wire logic               clk_sys,
  input  wire logic               cpuStall,
  input  wire logic [7:0]         ioRdata,
  output nvm_access_pkg::io_req_s ioReq
);
  logic stallHang = 1'b0; // set if a stall never ends
  initial ioReq = '0;
  // wait out a stall, then hold one access over one edge
  task automatic access(input logic w, input logic [1:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    #1;
    n = 0;
    while (cpuStall === 1'b1 && n < 8) begin // a halted core issues nothing
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 8) stallHang = 1'b1;
    ioReq = '{wr: w, rd: !w, index: idx, wdata: (w ? d : 8'h00)};
    @(posedge clk_sys);
    #1;
    ioReq = '0; // bus idles at zero, no stale data left
  endtask : access
  // register write
  task automatic wr(input logic [1:0] idx, input logic [7:0] d);
    access(1'b1, idx, d);
  endtask : wr
  // register read, data taken once the read edge has passed
  task automatic rd(input logic [1:0] idx, output logic [7:0] q);
    access(1'b0, idx, 8'h00);
    q = ioRdata;
  endtask : rd
endmodule : core_model

// ==== verification/byte_eeprom_access_control_tb.sv ====
// self-checking bench for the eeprom access block
// assumes the core model drives every register access
`timescale 1ns/1ps
module byte_eeprom_access_control_tb;
  localparam int ATOM  = 20; // shortened atomic time
  localparam int SPLIT = 10; // shortened erase or write time
  typedef struct packed {logic [1:0] m; logic [8:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic                    clk_sys = 1'b0;
  logic                    rst     = 1'b1;
  logic                    porRst  = 1'b1;
  logic                    ce      = 1'b1; // running, dropped only in the arm freeze case
  logic                    gieBit  = 1'b1;
  nvm_access_pkg::io_req_s ioReq;
  logic [7:0]              ioRdata;
  logic                    cpuStall;
  logic                    readyIrq;
  logic                    progBusy;
  logic [7:0]              q;
  int                      k;
  int                      error_cnt   = 0;
  int                      checks_done = 0;
  // mode, address, data, byte expected back; write-only ands into the byte
  row_s rows [6] = '{'{2'h0, 9'h1a3, 8'h5a, 8'h5a}, '{2'h1, 9'h1a3, 8'h00, 8'hff},
    '{2'h2, 9'h1a3, 8'h3c, 8'h3c}, '{2'h2, 9'h1a3, 8'hf0, 8'h30},
    '{2'h0, 9'h000, 8'ha5, 8'ha5}, '{2'h0, 9'h1ff, 8'h11, 8'h11}};
  byte_eeprom_access_control #(.ATOMIC_CYCLES(ATOM), .SPLIT_CYCLES(SPLIT)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .porRst(porRst), .ce(ce), .gieBit(gieBit),
    .ioReq(ioReq), .ioRdata(ioRdata), .cpuStall(cpuStall), .readyIrq(readyIrq),
    .progBusy(progBusy));
  core_model i_core (.clk_sys(clk_sys), .cpuStall(cpuStall), .ioRdata(ioRdata),
    .ioReq(ioReq));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // count stall cycles, bounded
  task automatic stall_len(output int n);
    n = 0;
    while (cpuStall === 1'b1 && n < 10) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : stall_len
  task automatic set_addr(input logic [8:0] a);
    i_core.wr(2'h0, {7'h00, a[8]});
    i_core.wr(2'h1, a[7:0]);
  endtask : set_addr
  // arm first, strobe next within the window, ready enable kept on
  task automatic start(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
    int n;
    set_addr(a);
    i_core.wr(2'h2, d);
    i_core.wr(2'h3, {2'h0, m, 4'hc});
    i_core.wr(2'h3, {2'h0, m, 4'ha});
    stall_len(n);
    check(8'(n), 8'h02);
    check(progBusy, 1'b1);
    check(readyIrq, 1'b0);
  endtask : start
  // wait for the end of programming, bounded
  task automatic finish(input int lo, input int hi);
    int n;
    n = 0;
    while (progBusy === 1'b1 && n <= hi) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(8'(n >= lo && n <= hi), 8'h01);
    check(readyIrq, 1'b1);
    if (progBusy !== 1'b0) close_out();
  endtask : finish
  task automatic readback(input logic [8:0] a, output logic [7:0] r);
    int n;
    set_addr(a);
    i_core.wr(2'h3, 8'h09);
    stall_len(n);
    check(8'(n), 8'h04);
    i_core.rd(2'h2, r);
  endtask : readback
  initial begin
    #(25 * 20000);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    porRst = 1'b0;
    i_core.rd(2'h2, q);
    check(q, 8'h00);
    i_core.rd(2'h3, q);
    check(q, 8'h00);
    check(readyIrq, 1'b0);
    i_core.wr(2'h0, 8'hff);
    i_core.rd(2'h0, q);
    check(q, 8'h01);
    i_core.wr(2'h3, 8'hc8);
    i_core.rd(2'h3, q);
    check(q, 8'h08);
    check(readyIrq, 1'b1);
    gieBit = 1'b0;
    #1 check(readyIrq, 1'b0);
    gieBit = 1'b1;
    // ordinary programming cases, each read back
    foreach (rows[i]) begin
      start(rows[i].m, rows[i].a, rows[i].d);
      finish((rows[i].m == 2'h0 ? ATOM : SPLIT) - 3, (rows[i].m == 2'h0 ? ATOM : SPLIT) - 1);
      readback(rows[i].a, q);
      check(q, rows[i].e);
    end
    // strobe unarmed, then strobe after the arm window ran out
    i_core.wr(2'h3, 8'h0a);
    check(cpuStall, 1'b0);
    check(progBusy, 1'b0);
    i_core.wr(2'h3, 8'h0c);
    repeat (5) @(posedge clk_sys);
    i_core.wr(2'h3, 8'h0a);
    check(progBusy, 1'b0);
    i_core.rd(2'h3, q);
    check(q, 8'h08);
    // reserved mode starts nothing
    i_core.wr(2'h3, 8'h3c);
    i_core.wr(2'h3, 8'h3a);
    check(progBusy, 1'b0);
    i_core.rd(2'h3, q);
    check(q & 8'hfb, 8'h38);
    i_core.wr(2'h3, 8'h08);
    // while busy: mode, address and read strobe are refused
    start(2'h0, 9'h055, 8'h77);
    i_core.wr(2'h3, 8'h18);
    i_core.wr(2'h1, 8'haa);
    i_core.wr(2'h3, 8'h09);
    check(cpuStall, 1'b0);
    i_core.rd(2'h3, q);
    check(q, 8'h0a);
    finish(0, ATOM);
    i_core.rd(2'h1, q);
    check(q, 8'h55);
    readback(9'h055, q);
    check(q, 8'h77);
    // device reset in mid-erase spares the operation and the mode
    start(2'h1, 9'h055, 8'h00);
    rst = 1'b1;
    @(posedge clk_sys);
    #1 rst = 1'b0;
    check(progBusy, 1'b1);
    i_core.rd(2'h3, q);
    check(q, 8'h12);
    // device reset cleared the ready enable; set it again, mode stays
    i_core.wr(2'h3, 8'h18);
    finish(0, SPLIT);
    readback(9'h055, q);
    check(q, 8'hff);
    // idle reset clears the mode field
    i_core.wr(2'h3, 8'h20);
    rst = 1'b1;
    @(posedge clk_sys);
    #1 rst = 1'b0;
    i_core.rd(2'h3, q);
    check(q, 8'h00);
    // clock enable low freezes the arm window, so a late strobe still starts
    i_core.wr(2'h3, 8'h0c);
    ce = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 ce = 1'b1;
    i_core.wr(2'h3, 8'h0a);
    stall_len(k);
    check(8'(k), 8'h02);
    check(progBusy, 1'b1);
    finish(ATOM - 3, ATOM - 1);
    check(i_core.stallHang, 1'b0);
    close_out();
  end
endmodule : byte_eeprom_access_control_tb
